// ### shared/oscpll_pkg.sv
// constants for the oscillator, pll and clock select block
`default_nettype none
package oscpll_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CLOCK_DIVIDER_REG  = 8'h00;
    localparam logic [7:0] OFS_FBD     = 8'h04;
    localparam logic [7:0] OFS_CTRL    = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
    // clock divider register fields
    localparam int PRE_LSB  = 0;
    localparam int PRE_W    = 5;
    localparam int POST_LSB = 6;
    localparam int POST_W   = 2;
    localparam int FRCD_LSB = 8;
    localparam int FRCD_W   = 3;
    localparam int FBD_W    = 9;
    // reset values
    localparam logic [10:0] CLOCK_DIVIDER_REG_RST = 11'h000;
    localparam logic [8:0]  FBD_RST    = 9'h01e;
    // divider encoding offsets
    localparam logic [5:0]  PRE_OFS    = 6'h02;
    localparam logic [9:0]  FBD_OFS    = 10'h002;
    localparam logic [8:0]  FIX_DIV16  = 9'h010;
    // interrupt bits
    localparam int IRQ_FAIL = 0;
    localparam int IRQ_BOOT = 1;
    localparam int IRQ_W    = 2;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // initial oscillator selection codes
    typedef enum logic [2:0] {
        OSC_FRC      = 3'b000,
        OSC_FRC_PLL  = 3'b001,
        OSC_PRI      = 3'b010,
        OSC_PRI_PLL  = 3'b011,
        OSC_SEC      = 3'b100,
        OSC_LOW_POWER_RC_OSC     = 3'b101,
        OSC_FRC_D16  = 3'b110,
        OSC_FRC_DN   = 3'b111
    } oscpll_mode_e;
    // primary oscillator mode codes
    localparam logic [1:0] PRI_EXT_CLK = 2'b00;
    localparam logic [1:0] PRI_XTAL    = 2'b01;
    localparam logic [1:0] PRI_HS_XTAL = 2'b10;
endpackage
`default_nettype wire

// ### rtl/oscpll_top.sv
// clock source select, fast rc postscaler, pll divider model and failure monitor
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module oscpll_top
    import oscpll_pkg::*;
#(
    parameter int FAIL_LIMIT = 4
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  nrst,
    // oscillator ticks, one cycle per source edge
    input  wire logic                  fast_rc_osc,
    input  wire logic                  primary_osc,
    input  wire logic                  secondary_osc,
    input  wire logic                  low_power_rc_osc,
    // configuration straps
    input  wire logic [2:0]            initial_osc_sel,
    input  wire logic [1:0]            primary_osc_mode_sel,
    // clock outputs as tick pulses, then drive mode, fail flag and interrupt
    output logic                       osc_clock,
    output logic                       instruction_clock,
    output logic                       wdt_ref_clock,
    output logic [1:0]                 primary_drive_mode,
    output logic                       clock_failure_monitor,
    output logic                       irq,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    // miss counter is eight bits wide and needs at least one reference tick
    if (FAIL_LIMIT < 1 || FAIL_LIMIT > 255) begin : g_limit_check
        $error("FAIL_LIMIT out of range");
    end

    logic [10:0]       clock_divider_reg_ff;
    logic [8:0]        fbd_ff;
    logic              mon_en_ff;
    logic [IRQ_W-1:0]  sts_ff;
    logic [IRQ_W-1:0]  msk_ff;
    oscpll_mode_e      mode_ff;
    logic [1:0]        pmode_ff;
    logic              booted_ff;
    logic              booted_d_ff;
    logic              fail_ff;
    logic [7:0]        miss_ff;
    logic [5:0]        pre_ff;
    logic [9:0]        burst_ff;
    logic [2:0]        post_ff;
    logic [7:0]        frc_ff;
    logic              half_ff;
    logic              osc_ff;
    logic              instr_ff;
    logic              wdt_ff;

    // boot selection: legal codes only, bad primary mode falls back to fast rc
    function automatic oscpll_mode_e boot_mode(input logic [2:0] sel, input logic [1:0] pm);
        oscpll_mode_e m;
        m = oscpll_mode_e'(sel);
        if ((sel == OSC_PRI || sel == OSC_PRI_PLL) && pm == 2'b11) begin
            m = OSC_FRC;
        end
        return m;
    endfunction

    // divider decode, offsets as encoded in the fields
    wire [5:0] n1     = {1'b0, clock_divider_reg_ff[PRE_LSB +: PRE_W]} + PRE_OFS;
    wire [9:0] mfac   = {1'b0, fbd_ff} + FBD_OFS;
    wire [1:0] post_s = clock_divider_reg_ff[POST_LSB +: POST_W];
    wire [2:0] n2     = (post_s == 2'b00) ? 3'd1 : (post_s == 2'b01) ? 3'd3 : 3'd7;
    wire [2:0] frc_s  = clock_divider_reg_ff[FRCD_LSB +: FRCD_W];
    wire [8:0] frc_dn = 9'h002 << frc_s;

    // fail-safe overrides the strap choice
    wire oscpll_mode_e eff_mode = fail_ff ? OSC_FRC : mode_ff;

    // only primary or fast rc may enter the pll
    wire pll_in_tick = (eff_mode == OSC_PRI_PLL) ? primary_osc : fast_rc_osc;
    wire pll_on      = (eff_mode == OSC_PRI_PLL) || (eff_mode == OSC_FRC_PLL);
    wire ref_tick    = pll_on && pll_in_tick && (pre_ff == n1 - 6'd1);
    wire vco_tick    = (burst_ff != 10'h000);
    wire pll_tick    = vco_tick && (post_ff == n2);

    wire [8:0] frc_div  = (eff_mode == OSC_FRC_D16) ? FIX_DIV16 : frc_dn;
    wire       frc_tick = fast_rc_osc && ({1'b0, frc_ff} == frc_div - 9'h001);

    logic fosc_tick;
    always_comb begin
        case (eff_mode)
            OSC_FRC:     fosc_tick = fast_rc_osc;
            OSC_FRC_PLL: fosc_tick = pll_tick;
            OSC_PRI:     fosc_tick = primary_osc;
            OSC_PRI_PLL: fosc_tick = pll_tick;
            OSC_SEC:     fosc_tick = secondary_osc;
            OSC_LOW_POWER_RC_OSC:    fosc_tick = low_power_rc_osc;
            default:     fosc_tick = frc_tick;
        endcase
    end

    // strap capture one cycle after release; reset itself loads constants only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            booted_ff <= 1'b0;
            mode_ff   <= OSC_FRC;
            pmode_ff  <= PRI_EXT_CLK;
        end else if (!booted_ff) begin
            booted_ff <= 1'b1;
            mode_ff   <= boot_mode(initial_osc_sel, primary_osc_mode_sel);
            pmode_ff  <= primary_osc_mode_sel;
        end
    end

    // pll model: prescale, burst of m vco ticks per reference, postscale
    wire [9:0] nxt_burst = burst_ff - {9'h000, vco_tick} + (ref_tick ? mfac : 10'h000);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pre_ff   <= 6'h00;
            burst_ff <= 10'h000;
            post_ff  <= 3'h0;
        end else begin
            if (!pll_on) begin
                pre_ff <= 6'h00;
            end else if (pll_in_tick) begin
                pre_ff <= ref_tick ? 6'h00 : pre_ff + 6'h01;
            end
            burst_ff <= pll_on ? nxt_burst : 10'h000;
            if (vco_tick) begin
                post_ff <= pll_tick ? 3'h0 : post_ff + 3'h1;
            end
        end
    end

    // fast rc postscaler, instruction clock halving, watchdog reference
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frc_ff   <= 8'h00;
            half_ff  <= 1'b0;
            osc_ff   <= 1'b0;
            instr_ff <= 1'b0;
            wdt_ff   <= 1'b0;
        end else begin
            if (fast_rc_osc) begin
                frc_ff <= frc_tick ? 8'h00 : frc_ff + 8'h01;
            end
            if (fosc_tick) begin
                half_ff <= ~half_ff;
            end
            osc_ff   <= fosc_tick;
            instr_ff <= fosc_tick && half_ff;
            wdt_ff   <= low_power_rc_osc;
        end
    end

    // monitor counts reference ticks without a system tick; sticky until reset
    wire fail_hit = mon_en_ff && low_power_rc_osc && (miss_ff == 8'(FAIL_LIMIT - 1));
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            miss_ff <= 8'h00;
            fail_ff <= 1'b0;
        end else begin
            if (fosc_tick || !mon_en_ff || fail_ff) begin
                miss_ff <= 8'h00;
            end else if (low_power_rc_osc) begin
                miss_ff <= miss_ff + 8'h01;
            end
            if (fail_hit && !fosc_tick && booted_ff) begin
                fail_ff <= 1'b1;
            end
        end
    end

    // axi4-lite: write taken when address and data are both offered
    wire wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_go  = s_axi_arvalid && !s_axi_rvalid;
    wire wa_div = (s_axi_awaddr == OFS_CLOCK_DIVIDER_REG);
    wire wa_fbd = (s_axi_awaddr == OFS_FBD);
    wire wa_ctl = (s_axi_awaddr == OFS_CTRL);
    wire wa_sts = (s_axi_awaddr == OFS_IRQ_STS);
    wire wa_msk = (s_axi_awaddr == OFS_IRQ_MSK);
    wire wa_ok  = wa_div || wa_fbd || wa_ctl || wa_sts || wa_msk || (s_axi_awaddr == OFS_STATUS);
    wire [10:0] div_be = {s_axi_wstrb[1] ? s_axi_wdata[10:8] : clock_divider_reg_ff[10:8],
                          s_axi_wstrb[0] ? s_axi_wdata[7:0] : clock_divider_reg_ff[7:0]};
    wire [8:0]  fbd_be = {s_axi_wstrb[1] ? s_axi_wdata[8] : fbd_ff[8],
                          s_axi_wstrb[0] ? s_axi_wdata[7:0] : fbd_ff[7:0]};
    wire [IRQ_W-1:0] clr = (wr_go && wa_sts && s_axi_wstrb[0]) ?
                           s_axi_wdata[IRQ_W-1:0] : '0;
    // delayed boot flag marks the single cycle after strap capture
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            booted_d_ff <= 1'b0;
        end else begin
            booted_d_ff <= booted_ff;
        end
    end
    // fail event only when the fail flag really rises
    wire fail_set = fail_hit && !fosc_tick && booted_ff && !fail_ff;
    wire [IRQ_W-1:0] evt = {booted_ff && !booted_d_ff, fail_set};
    wire [IRQ_W-1:0] nxt_sts = (sts_ff & ~clr) | evt;

    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (s_axi_araddr == OFS_CLOCK_DIVIDER_REG) begin
            rd_val[10:0] = clock_divider_reg_ff;
        end else if (s_axi_araddr == OFS_FBD) begin
            rd_val[8:0] = fbd_ff;
        end else if (s_axi_araddr == OFS_CTRL) begin
            rd_val[0] = mon_en_ff;
        end else if (s_axi_araddr == OFS_STATUS) begin
            rd_val[6:0] = {booted_ff, fail_ff, pmode_ff, eff_mode};
        end else if (s_axi_araddr == OFS_IRQ_STS) begin
            rd_val[IRQ_W-1:0] = sts_ff;
        end else if (s_axi_araddr == OFS_IRQ_MSK) begin
            rd_val[IRQ_W-1:0] = msk_ff;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clock_divider_reg_ff    <= CLOCK_DIVIDER_REG_RST;
            fbd_ff       <= FBD_RST;
            mon_en_ff    <= 1'b1;
            msk_ff       <= '0;
            sts_ff       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            sts_ff <= nxt_sts; // set wins over clear
            if (wr_go) begin
                if (wa_div) clock_divider_reg_ff <= div_be;
                if (wa_fbd) fbd_ff <= fbd_be;
                if (wa_ctl && s_axi_wstrb[0]) mon_en_ff <= s_axi_wdata[0];
                if (wa_msk && s_axi_wstrb[0]) msk_ff <= s_axi_wdata[IRQ_W-1:0];
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready         = wr_go;
    assign s_axi_wready          = wr_go;
    assign s_axi_arready         = rd_go;
    assign osc_clock             = osc_ff;
    assign instruction_clock     = instr_ff;
    assign wdt_ref_clock         = wdt_ff;
    assign primary_drive_mode    = pmode_ff;
    assign clock_failure_monitor = fail_ff;
    assign irq                   = |(sts_ff & msk_ff);

    a_fail_forces_frc: assert property (@(posedge clock) disable iff (!nrst)
        fail_ff |=> (osc_ff == $past(fast_rc_osc))) else $error("fail-safe not on fast rc");
    a_instr_halves: assert property (@(posedge clock) disable iff (!nrst)
        instr_ff |=> !instr_ff) else $error("instruction tick not halved");
    a_instr_cause: assert property (@(posedge clock) disable iff (!nrst)
        instr_ff |-> $past(fosc_tick) && $past(half_ff)) else $error("instruction tick uncaused");
    a_burst_load: assert property (@(posedge clock) disable iff (!nrst)
        (pll_on && ref_tick && !vco_tick) |=> (burst_ff == $past(mfac)))
        else $error("vco burst not m");
    a_pre_wrap: assert property (@(posedge clock) disable iff (!nrst)
        pll_on |-> (pre_ff < n1)) else $error("prescale count overran");
    a_post_wrap: assert property (@(posedge clock) disable iff (!nrst)
        post_ff <= n2) else $error("postscale count overran");
    a_frc_wrap: assert property (@(posedge clock) disable iff (!nrst)
        ({1'b0, frc_ff} < frc_div) || !fast_rc_osc) else $error("fast rc count overran");
    a_erased_boot: assert property (@(posedge clock) disable iff (!nrst)
        (!booted_ff && initial_osc_sel == 3'b111) |=> (mode_ff == OSC_FRC_DN))
        else $error("erased straps not fast rc");
    a_fail_irq: assert property (@(posedge clock) disable iff (!nrst)
        $rose(fail_ff) |-> sts_ff[IRQ_FAIL]) else $error("fail event not flagged");
    a_wdt_ref: assert property (@(posedge clock) disable iff (!nrst)
        low_power_rc_osc |=> wdt_ff) else $error("watchdog reference lost");
    a_bresp_hold: assert property (@(posedge clock) disable iff (!nrst)
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped");

    c_pll_out: cover property (@(posedge clock) disable iff (!nrst) pll_on && pll_tick);
    c_fail: cover property (@(posedge clock) disable iff (!nrst) $rose(fail_ff));
    c_frc_div: cover property (@(posedge clock) disable iff (!nrst)
        eff_mode == OSC_FRC_DN && frc_tick);
    c_irq: cover property (@(posedge clock) disable iff (!nrst) $rose(irq));
endmodule
`default_nettype wire

// ### tb/oscpll_src_model.sv
// oscillator sources beside the clock block, as tick trains
`default_nettype none
module oscpll_src_model (
    // clock
    input  wire logic       clock,
    // tick spacing in cycles, zero stops the source
    input  wire logic [7:0] per_fast,
    input  wire logic [7:0] per_pri,
    input  wire logic [7:0] per_sec,
    input  wire logic [7:0] per_lp,
    // source ticks
    output logic            fast_tick,
    output logic            pri_tick,
    output logic            sec_tick,
    output logic            lp_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0][7:0] per;
    logic [3:0][7:0] cnt_ff = '0;
    logic [3:0]      tick_ff = 4'h0;
    assign per = {per_lp, per_sec, per_pri, per_fast};
    assign {lp_tick, sec_tick, pri_tick, fast_tick} = tick_ff;
    // a stopped crystal gives no edges at all, so its line stays low
    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            tick_ff[i] <= per[i] != 8'h00 && cnt_ff[i] + 8'h01 >= per[i];
            if (per[i] == 8'h00 || cnt_ff[i] + 8'h01 >= per[i]) begin
                cnt_ff[i] <= 8'h00;
            end else begin
                cnt_ff[i] <= cnt_ff[i] + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/oscpll_top_tb.sv
// self-checking bench for the clock select block
`default_nettype none
module oscpll_top_tb import oscpll_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0]  sel;
        logic [1:0]  pm;
        logic [10:0] div;
        logic [8:0]  fbd;
        logic [2:0]  mode;
        logic [15:0] n;
    } oscpll_row_s;
    // pll rows keep vco input, vco output and pll output in range
    localparam oscpll_row_s ROWS [14] = '{
        '{3'b000, 2'b00, 11'h000, 9'h01e, 3'b000, 16'h004b},
        '{3'b001, 2'b00, 11'h000, 9'h01e, 3'b001, 16'h0258},
        '{3'b010, 2'b00, 11'h000, 9'h01e, 3'b010, 16'h0096},
        '{3'b010, 2'b01, 11'h000, 9'h01e, 3'b010, 16'h0096},
        '{3'b010, 2'b10, 11'h000, 9'h01e, 3'b010, 16'h0096},
        '{3'b011, 2'b00, 11'h000, 9'h01e, 3'b011, 16'h04b0},
        '{3'b011, 2'b01, 11'h041, 9'h01e, 3'b011, 16'h0190},
        '{3'b011, 2'b10, 11'h080, 9'h01e, 3'b011, 16'h012c},
        '{3'b100, 2'b00, 11'h080, 9'h01e, 3'b100, 16'h0064},
        '{3'b101, 2'b00, 11'h080, 9'h01e, 3'b101, 16'h003c},
        '{3'b110, 2'b00, 11'h000, 9'h01e, 3'b110, 16'h0004},
        '{3'b111, 2'b00, 11'h200, 9'h01e, 3'b111, 16'h0009},
        '{3'b111, 2'b11, 11'h000, 9'h01e, 3'b111, 16'h0025},
        '{3'b010, 2'b11, 11'h000, 9'h01e, 3'b000, 16'h004b}
    };
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  initial_osc_sel = 3'h0;
    logic [1:0]  primary_osc_mode_sel = 2'h0;
    logic [7:0]  per_pri = 8'h14;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         fast_rc_osc, primary_osc, secondary_osc, low_power_rc_osc;
    wire         osc_clock, instruction_clock, wdt_ref_clock, clock_failure_monitor, irq;
    wire [1:0]   primary_drive_mode, s_axi_bresp, s_axi_rresp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [31:0]  s_axi_rdata;
    int          err_count = 0;
    int          compares = 0;
    oscpll_src_model u_src (
        .clock, .per_fast(8'h28), .per_pri, .per_sec(8'h1e), .per_lp(8'h32),
        .fast_tick(fast_rc_osc), .pri_tick(primary_osc), .sec_tick(secondary_osc),
        .lp_tick(low_power_rc_osc)
    );
    oscpll_top #(.FAIL_LIMIT(2)) u_dut (
        .clock, .nrst, .fast_rc_osc, .primary_osc, .secondary_osc, .low_power_rc_osc,
        .initial_osc_sel, .primary_osc_mode_sel, .osc_clock, .instruction_clock,
        .wdt_ref_clock, .primary_drive_mode, .clock_failure_monitor, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // pll output comes in bursts, so a window count is only near its mean
    function automatic logic near(input int a, input int e);
        return a >= e - e / 16 - 2 && a <= e + e / 16 + 2;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        #1;
        while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        #1;
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        r = s_axi_bresp;
        @(posedge clock);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        #1;
        while (s_axi_arready !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        s_axi_arvalid <= 1'b0;
        #1;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clock);
        s_axi_rready <= 1'b0;
    endtask
    task automatic boot(input logic [2:0] s, input logic [1:0] m);
        @(posedge clock);
        nrst <= 1'b0;
        initial_osc_sel <= s;
        primary_osc_mode_sel <= m;
        repeat (4) @(posedge clock);
        chk("reset outputs", 32'({osc_clock, instruction_clock, wdt_ref_clock, irq,
            clock_failure_monitor, s_axi_awready, s_axi_bvalid, s_axi_rvalid}), 32'h0);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic count(output int co, output int ci, output int cw);
        co = 0;
        ci = 0;
        cw = 0;
        repeat (3000) begin
            @(posedge clock);
            #1;
            co += int'(osc_clock);
            ci += int'(instruction_clock);
            cw += int'(wdt_ref_clock);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #240000;
        err_count++;
        $display("watchdog ran out");
        wrap_up();
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          co;
        int          ci;
        int          cw;
        foreach (ROWS[i]) begin
            boot(ROWS[i].sel, ROWS[i].pm);
            // slow sources would otherwise trip the monitor between ticks
            wr(OFS_CTRL, 32'h0, r);
            wr(OFS_CLOCK_DIVIDER_REG, 32'(ROWS[i].div), r);
            wr(OFS_FBD, 32'(ROWS[i].fbd), r);
            rd(OFS_CLOCK_DIVIDER_REG, d, r);
            chk("divider", d, 32'(ROWS[i].div));
            rd(OFS_STATUS, d, r);
            chk("mode", 32'({d[6], d[2:0]}), 32'({1'b1, ROWS[i].mode}));
            if (ROWS[i].sel[2:1] == 2'b01 && ROWS[i].pm != 2'b11) begin
                chk("drive mode", 32'(primary_drive_mode), 32'(ROWS[i].pm));
            end
            count(co, ci, cw);
            chk("osc count", 32'(near(co, ROWS[i].n)), 32'h1);
            chk("instr count", 32'(near(ci, ROWS[i].n / 2)), 32'h1);
            chk("wdt count", 32'(near(cw, 60)), 32'h1);
            $display("row %0d done", i);
        end
        boot(3'b010, 2'b01);
        rd(OFS_FBD, d, r);
        chk("feedback reset", d, 32'(FBD_RST));
        rd(OFS_CLOCK_DIVIDER_REG, d, r);
        chk("divider reset", d, 32'(CLOCK_DIVIDER_REG_RST));
        // low byte strobe only: bits 10:8 keep their reset value
        s_axi_wstrb <= 4'h1;
        wr(OFS_CLOCK_DIVIDER_REG, 32'h7ff, r);
        s_axi_wstrb <= 4'hf;
        rd(OFS_CLOCK_DIVIDER_REG, d, r);
        chk("byte strobe", d, 32'h0ff);
        wr(OFS_IRQ_MSK, 32'h3, r);
        #1;
        chk("boot irq", 32'(irq), 32'h1);
        rd(OFS_IRQ_STS, d, r);
        chk("irq status", d, 32'h2);
        wr(OFS_IRQ_STS, 32'h2, r);
        #1;
        chk("irq cleared", 32'(irq), 32'h0);
        @(posedge clock);
        per_pri <= 8'h00;
        count(co, ci, cw);
        chk("fail flag", 32'(clock_failure_monitor), 32'h1);
        chk("fallback count", 32'(near(co, 71)), 32'h1);
        chk("fail irq", 32'(irq), 32'h1);
        rd(OFS_STATUS, d, r);
        chk("fail status", 32'({d[5], d[2:0]}), 32'h8);
        wr(OFS_IRQ_MSK, 32'h2, r);
        #1;
        chk("masked irq", 32'(irq), 32'h0);
        wr(OFS_IRQ_STS, 32'h1, r);
        wr(OFS_IRQ_MSK, 32'h3, r);
        #1;
        chk("fail irq cleared", 32'(irq), 32'h0);
        wr(8'h40, 32'h1, r);
        chk("unmapped write", 32'(r), 32'(RESP_SLVERR));
        rd(8'h40, d, r);
        chk("unmapped read", 32'(r), 32'(RESP_SLVERR));
        chk("unmapped data", d, 32'h0);
        wr(OFS_STATUS, 32'h0, r);
        chk("status write", 32'(r), 32'(RESP_OKAY));
        $display("monitor test done");
        @(posedge clock);
        per_pri <= 8'h14;
        boot(3'b010, 2'b01);
        chk("fail after reset", 32'(clock_failure_monitor), 32'h0);
        $display("reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire
